/* rbt_pkg.sv */
// constants and types for the roi, binning and trigger control block
// What this block does
// - gain code in tenth dB, -6 to +12
// - signed dc offset code -128..127, sixteenth DN
// - vertical crop stops reading after the last requested line
// - horizontal crop: fewer pixels from left offset
// - window starts at top offset, height lines
// - both crops together give rectangular region
// - output eight or ten bit pixels
// - offsets shrink maximum width and height
// - flip mirrors each line horizontally
// - binned axis uses halved coordinates
// - independent two cell binning per axis
// - binning code 1 off, 2 combined
// - vertical binning raises maximum frame rate
// - report line stride in bytes
// - exposure starts from one selected source
// - free-run timer, exposure at least 100 us
// - free-run exposure aligned to line timing
// - external trigger passes programmable debounce
// - software trigger starts exposure directly
package rbt_pkg;
  // register indices, one aligned word each
  localparam logic [7:0] REG_GAIN      = 8'h00;
  localparam logic [7:0] REG_OFFSET    = 8'h04;
  localparam logic [7:0] REG_LEFT      = 8'h08;
  localparam logic [7:0] REG_TOP       = 8'h0c;
  localparam logic [7:0] REG_WIDTH     = 8'h10;
  localparam logic [7:0] REG_HEIGHT    = 8'h14;
  localparam logic [7:0] REG_FORMAT    = 8'h18;
  localparam logic [7:0] REG_BINNING   = 8'h1c;
  localparam logic [7:0] REG_TRIGGER   = 8'h20;
  localparam logic [7:0] REG_PERIOD    = 8'h24;
  localparam logic [7:0] REG_EXPOSURE  = 8'h28;
  localparam logic [7:0] REG_DEBOUNCE  = 8'h2c;
  localparam logic [7:0] REG_SOFT_TRIG = 8'h30;
  localparam logic [7:0] REG_STRIDE    = 8'h34;
  localparam logic [7:0] REG_STATUS    = 8'h38;
  localparam logic [7:0] REG_EFFECTIVE = 8'h3c;
  // gain range in tenth dB, two's complement
  localparam logic signed [15:0] GAIN_MIN_CODE = -16'sd60;
  localparam logic signed [15:0] GAIN_MAX_CODE = 16'sd120;
  localparam logic [15:0] GAIN_RESET = 16'h0000;
  localparam logic [7:0]  OFFSET_RESET = 8'h00;
  // binning codes
  localparam logic [1:0] BIN_OFF = 2'h1;
  localparam logic [1:0] BIN_TWO = 2'h2;
  // timing
  localparam int CLK_MHZ = 200;
  localparam int MIN_EXPOSURE_US = 100;
  localparam int MIN_EXPOSURE_CYC = MIN_EXPOSURE_US * CLK_MHZ;
  localparam int LINE_PERIOD_CYC = 6354;
  localparam logic [31:0] PERIOD_RESET   = 32'h01312d00;
  localparam logic [31:0] EXPOSURE_RESET = 32'h00004e20;
  localparam logic [15:0] DEBOUNCE_RESET = 16'h00c8;
  // pixel format
  typedef enum logic [0:0] {
    FMT_MONO8  = 1'b0,
    FMT_MONO10 = 1'b1
  } rbt_format_t;
  // trigger source
  typedef enum logic [1:0] {
    SRC_FREE_RUN = 2'b00,
    SRC_EXTERNAL = 2'b01,
    SRC_SOFTWARE = 2'b10
  } rbt_source_t;
  // readout states
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ALIGN  = 2'b01,
    ST_EXPOSE = 2'b10,
    ST_READ   = 2'b11
  } rbt_state_t;
endpackage

/* rbt_pix_if.sv */
// pixel stream carrier between readout core and line mirror
`timescale 1ns/100ps
interface rbt_pix_if #(parameter int PW = 10, parameter int XW = 12);
  logic          valid;
  logic [PW-1:0] data;
  logic [XW-1:0] col;
  logic          last;
  logic          flip;
  logic [XW-1:0] width;
  logic          out_valid;
  logic [PW-1:0] out_data;
  logic          out_last;
  modport core   (output valid, data, col, last, flip, width, input out_valid, out_data, out_last);
  modport mirror (input valid, data, col, last, flip, width, output out_valid, out_data, out_last);
endinterface

/* rbt_line_mirror.sv */
// two-bank line buffer that mirrors a line when flip is set
`timescale 1ns/100ps
module rbt_line_mirror
  import rbt_pkg::*;
#(
  parameter int PW = 10,
  parameter int XW = 12
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // pixel stream
  rbt_pix_if.mirror pix
);
  typedef struct packed {
    logic          bank;
    logic          playing;
    logic [XW-1:0] rd_col;
    logic [XW-1:0] rd_len;
    logic          out_valid;
    logic [PW-1:0] out_data;
    logic          out_last;
  } rbt_mir_t;
  rbt_mir_t      mir_reg;
  rbt_mir_t      mir_next;
  logic [PW-1:0] line_mem [2][1<<XW];
  // reading the mirror address from the far bank frees the writer to fill the next line
  always_comb begin
    mir_next           = mir_reg;
    mir_next.out_valid = 1'b0;
    mir_next.out_last  = 1'b0;
    if (pix.valid && pix.last) begin
      mir_next.playing = 1'b1;
      mir_next.rd_col  = '0;
      mir_next.rd_len  = pix.col;
      mir_next.bank    = ~mir_reg.bank;
    end else if (mir_reg.playing) begin
      mir_next.out_valid = 1'b1;
      mir_next.out_data  = line_mem[~mir_reg.bank][pix.flip ? mir_reg.rd_len - mir_reg.rd_col : mir_reg.rd_col];
      mir_next.out_last  = (mir_reg.rd_col == mir_reg.rd_len);
      mir_next.rd_col    = mir_reg.rd_col + 1'b1;
      if (mir_reg.rd_col == mir_reg.rd_len) begin
        mir_next.playing = 1'b0;
      end
    end
    if (!rst_b) begin
      mir_next = '0;
    end
  end
  // line store write and state register
  always_ff @(posedge clk) begin
    mir_reg <= mir_next;
    if (pix.valid) begin
      line_mem[mir_reg.bank][pix.col] <= pix.data;
    end
  end
  assign pix.out_valid = mir_reg.out_valid;
  assign pix.out_data  = mir_reg.out_data;
  assign pix.out_last  = mir_reg.out_last;
endmodule

/* rbt_roi_control.sv */
// acquisition control: gain, offset, window, binning, format and trigger source
`timescale 1ns/100ps
module rbt_roi_control
  import rbt_pkg::*;
#(
  parameter int          SENSOR_W   = 640,
  parameter int          SENSOR_H   = 480,
  parameter int          XW         = 12,
  parameter logic [31:0] LINE_CYC   = 32'(LINE_PERIOD_CYC),
  parameter logic [31:0] MIN_EXP    = 32'(MIN_EXPOSURE_CYC)
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_b,
  // register port
  input  wire logic [7:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [31:0]   reg_rdata,
  // sensor side
  input  wire logic          sensor_valid,
  input  wire logic [9:0]    sensor_data,
  input  wire logic          ext_trigger,
  output logic      [15:0]   analog_gain_code,
  output logic      [7:0]    dc_offset_code,
  output logic               bin_horiz,
  output logic               bin_vert,
  output logic               expose,
  output logic               line_tick,
  // pixel output to host
  output logic               out_valid,
  output logic      [9:0]    out_data,
  output logic               out_last,
  output logic               frame_done
);
  initial begin
    if (SENSOR_W >= (1 << XW) || SENSOR_H >= (1 << XW) || SENSOR_W < 2 || SENSOR_H < 2) begin
      $error("sensor size does not fit the coordinate width");
    end
    // the effective size readback packs each maximum into a twelve bit field
    if (SENSOR_W > 4095 || SENSOR_H > 4095) begin
      $error("sensor size does not fit the readback fields");
    end
    // a halved line period below one cycle would wrap the line counter
    if (LINE_CYC < 32'h2 || MIN_EXP == 32'h0) begin
      $error("line period or minimum exposure too short");
    end
  end

  typedef struct packed {
    logic [15:0]   gain;
    logic [7:0]    offset;
    logic [XW-1:0] left;
    logic [XW-1:0] top;
    logic [XW-1:0] width;
    logic [XW-1:0] height;
    rbt_format_t   fmt;
    logic          flip;
    logic [1:0]    hbin;
    logic [1:0]    vbin;
    rbt_source_t   src;
    logic [31:0]   period;
    logic [31:0]   exposure;
    logic [15:0]   debounce;
    logic          soft_pend;
    logic [31:0]   rdata;
    logic [1:0]    ext_sync;
    logic          ext_filt;
    logic [15:0]   db_cnt;
    logic [31:0]   frame_cnt;
    logic [31:0]   line_cnt;
    logic          tick;
    rbt_state_t    state;
    logic [31:0]   exp_cnt;
    logic [XW-1:0] row;
    logic [XW-1:0] col;
    logic          vhalf;
    logic          hhalf;
    logic          pend;
    logic          pvalid;
    logic [9:0]    pdata;
    logic [XW-1:0] pcol;
    logic          plast;
    logic          done;
  } rbt_ctl_t;

  rbt_ctl_t r_reg;
  rbt_ctl_t r_next;

  // halve the sensor extent when binned, then clamp a range against it in binned units
  function automatic logic [XW-1:0] span_max(input int extent, input logic [1:0] bin);
    span_max = (bin == BIN_TWO) ? XW'(extent / 2) : XW'(extent);
  endfunction

  function automatic logic [XW-1:0] clamp_size(input logic [XW-1:0] off, input logic [XW-1:0] size,
                                               input logic [XW-1:0] lim);
    logic [XW-1:0] room;
    room = (off >= lim) ? XW'(1) : lim - off;
    clamp_size = (size == '0) ? XW'(1) : ((size > room) ? room : size);
  endfunction

  function automatic logic [1:0] bin_code(input logic [1:0] v);
    bin_code = (v == BIN_TWO) ? BIN_TWO : BIN_OFF;
  endfunction

  function automatic logic [15:0] gain_clamp(input logic [15:0] v);
    if ($signed(v) < GAIN_MIN_CODE) begin
      gain_clamp = GAIN_MIN_CODE;
    end else if ($signed(v) > GAIN_MAX_CODE) begin
      gain_clamp = GAIN_MAX_CODE;
    end else begin
      gain_clamp = v;
    end
  endfunction

  logic [XW-1:0] wmax;
  logic [XW-1:0] hmax;
  logic [XW-1:0] eff_left;
  logic [XW-1:0] eff_top;
  logic [XW-1:0] eff_w;
  logic [XW-1:0] eff_h;
  logic [31:0]   stride;
  logic          start_req;
  logic [31:0]   exp_need;

  rbt_pix_if #(.PW(10), .XW(XW)) pix ();

  // effective window in the coordinate system of the current binning
  always_comb begin
    wmax     = span_max(SENSOR_W, r_reg.hbin);
    hmax     = span_max(SENSOR_H, r_reg.vbin);
    eff_left = (r_reg.left >= wmax) ? wmax - XW'(2) : {r_reg.left[XW-1:1], 1'b0};
    eff_top  = (r_reg.top >= hmax) ? hmax - XW'(1) : r_reg.top;
    eff_w    = clamp_size(eff_left, {r_reg.width[XW-1:1], 1'b0}, wmax);
    eff_h    = clamp_size(eff_top, r_reg.height, hmax);
    stride   = (r_reg.fmt == FMT_MONO10) ? {{(31-XW){1'b0}}, eff_w, 1'b0}
                                         : {{(32-XW){1'b0}}, eff_w};
    exp_need = (r_reg.exposure < MIN_EXP) ? MIN_EXP : r_reg.exposure;
    case (r_reg.src)
      SRC_FREE_RUN: start_req = (r_reg.frame_cnt == '0);
      SRC_EXTERNAL: start_req = r_reg.ext_filt && (r_reg.db_cnt == r_reg.debounce) && !r_reg.pend;
      SRC_SOFTWARE: start_req = r_reg.soft_pend;
      default:      start_req = 1'b0;
    endcase
  end

  // register port, trigger filter, frame timer and readout sequence
  always_comb begin
    r_next        = r_reg;
    r_next.rdata  = '0;
    r_next.pvalid = 1'b0;
    r_next.plast  = 1'b0;
    r_next.done   = 1'b0;
    // register reads, data stand one cycle later
    if (reg_rd) begin
      case (reg_addr)
        REG_GAIN:      r_next.rdata = {16'h0000, r_reg.gain};
        REG_OFFSET:    r_next.rdata = {{24{r_reg.offset[7]}}, r_reg.offset};
        REG_LEFT:      r_next.rdata = 32'(r_reg.left);
        REG_TOP:       r_next.rdata = 32'(r_reg.top);
        REG_WIDTH:     r_next.rdata = 32'(eff_w);
        REG_HEIGHT:    r_next.rdata = 32'(eff_h);
        REG_FORMAT:    r_next.rdata = {30'h0, r_reg.flip, r_reg.fmt};
        REG_BINNING:   r_next.rdata = {28'h0, r_reg.vbin, r_reg.hbin};
        REG_TRIGGER:   r_next.rdata = {30'h0, r_reg.src};
        REG_PERIOD:    r_next.rdata = r_reg.period;
        REG_EXPOSURE:  r_next.rdata = r_reg.exposure;
        REG_DEBOUNCE:  r_next.rdata = {16'h0000, r_reg.debounce};
        REG_STRIDE:    r_next.rdata = stride;
        REG_STATUS:    r_next.rdata = {28'h0, r_reg.soft_pend, r_reg.ext_filt, r_reg.state};
        REG_EFFECTIVE: r_next.rdata = {4'h0, 12'(wmax), 4'h0, 12'(hmax)};
        default:       r_next.rdata = '0;
      endcase
    end
    // register writes take effect on the next clock, even while a frame is being read
    if (reg_wr) begin
      case (reg_addr)
        REG_GAIN:      r_next.gain     = gain_clamp(reg_wdata[15:0]);
        REG_OFFSET:    r_next.offset   = reg_wdata[7:0];
        REG_LEFT:      r_next.left     = reg_wdata[XW-1:0];
        REG_TOP:       r_next.top      = reg_wdata[XW-1:0];
        REG_WIDTH:     r_next.width    = reg_wdata[XW-1:0];
        REG_HEIGHT:    r_next.height   = reg_wdata[XW-1:0];
        REG_FORMAT: begin
          r_next.fmt  = rbt_format_t'(reg_wdata[0]);
          r_next.flip = reg_wdata[1];
        end
        REG_BINNING: begin
          r_next.hbin = bin_code(reg_wdata[1:0]);
          r_next.vbin = bin_code(reg_wdata[3:2]);
        end
        REG_TRIGGER:   r_next.src      = (reg_wdata[1:0] == 2'b11) ? SRC_FREE_RUN : rbt_source_t'(reg_wdata[1:0]);
        REG_PERIOD:    r_next.period   = reg_wdata;
        REG_EXPOSURE:  r_next.exposure = reg_wdata;
        REG_DEBOUNCE:  r_next.debounce = reg_wdata[15:0];
        default: begin
        end
      endcase
    end
    // a software trigger only raises a request: no parameter check, no buffer change
    if (reg_wr && reg_addr == REG_SOFT_TRIG && r_reg.src == SRC_SOFTWARE) begin
      r_next.soft_pend = 1'b1;
    end
    // debounce: filtered level rises only after the input stays high; it falls without a stability wait
    r_next.ext_sync = {r_reg.ext_sync[0], ext_trigger};
    if (r_reg.ext_sync[1] != r_reg.ext_filt) begin
      if (r_reg.db_cnt >= r_reg.debounce) begin
        r_next.ext_filt = r_reg.ext_sync[1];
        r_next.db_cnt   = '0;
      end else begin
        r_next.db_cnt = r_reg.db_cnt + 16'h0001;
      end
    end else if (r_reg.ext_filt && r_reg.db_cnt != r_reg.debounce) begin
      r_next.db_cnt = r_reg.db_cnt + 16'h0001;
    end else if (!r_reg.ext_filt) begin
      r_next.db_cnt = '0;
    end
    if (start_req && r_reg.src == SRC_EXTERNAL) begin
      r_next.pend = 1'b1;
    end
    if (!r_reg.ext_filt) begin
      r_next.pend = 1'b0;
    end
    // free-run frame timer; a period of zero means run at the sensor maximum
    if (r_reg.frame_cnt == '0) begin
      r_next.frame_cnt = (r_reg.period == '0) ? '0 : r_reg.period - 32'h1;
    end else begin
      r_next.frame_cnt = r_reg.frame_cnt - 32'h1;
    end
    // horizontal line timing; vertical binning halves line time per output row
    r_next.tick = 1'b0;
    if (r_reg.line_cnt == '0) begin
      r_next.line_cnt = (r_reg.vbin == BIN_TWO) ? (LINE_CYC >> 1) - 32'h1 : LINE_CYC - 32'h1;
      r_next.tick     = 1'b1;
    end else begin
      r_next.line_cnt = r_reg.line_cnt - 32'h1;
    end
    // exposure and readout sequence; starts while busy are ignored, but a software request stays pending
    case (r_reg.state)
      ST_IDLE: begin
        if (start_req) begin
          // a trigger written in the starting cycle stays pending: set wins over clear
          r_next.soft_pend = reg_wr && reg_addr == REG_SOFT_TRIG && r_reg.src == SRC_SOFTWARE;
          r_next.exp_cnt   = exp_need;
          r_next.state     = (r_reg.src == SRC_FREE_RUN) ? ST_ALIGN : ST_EXPOSE;
        end
      end
      ST_ALIGN: begin
        if (r_reg.tick) begin
          r_next.state = ST_EXPOSE;
        end
      end
      ST_EXPOSE: begin
        r_next.exp_cnt = r_reg.exp_cnt - 32'h1;
        if (r_reg.exp_cnt <= 32'h1) begin
          r_next.state = ST_READ;
          r_next.row   = '0;
          r_next.col   = '0;
          r_next.vhalf = 1'b0;
          r_next.hhalf = 1'b0;
        end
      end
      ST_READ: begin
        if (sensor_valid) begin
          // binned cells arrive as pairs; only the second of a pair counts as a step
          r_next.hhalf = (r_reg.hbin == BIN_TWO) ? ~r_reg.hhalf : 1'b0;
          if (r_reg.hbin != BIN_TWO || r_reg.hhalf) begin
            // only rows and columns inside the window leave the block
            if (r_reg.row >= eff_top && r_reg.row < eff_top + eff_h &&
                r_reg.col >= eff_left && r_reg.col < eff_left + eff_w &&
                (r_reg.vbin != BIN_TWO || r_reg.vhalf)) begin
              r_next.pvalid = 1'b1;
              r_next.pdata  = (r_reg.fmt == FMT_MONO8) ? {2'b00, sensor_data[9:2]} : sensor_data;
              r_next.pcol   = r_reg.col - eff_left;
              r_next.plast  = (r_reg.col == eff_left + eff_w - XW'(1));
            end
            r_next.col = r_reg.col + XW'(1);
            if (r_reg.col == wmax - XW'(1)) begin
              r_next.col   = '0;
              r_next.vhalf = (r_reg.vbin == BIN_TWO) ? ~r_reg.vhalf : 1'b0;
              if (r_reg.vbin != BIN_TWO || r_reg.vhalf) begin
                r_next.row = r_reg.row + XW'(1);
                // stop at the last window row: lines below are never read
                if (r_reg.row == eff_top + eff_h - XW'(1)) begin
                  r_next.state = ST_IDLE;
                  r_next.done  = 1'b1;
                end
              end
            end
          end
        end
      end
      default: r_next.state = ST_IDLE;
    endcase
    if (!rst_b) begin
      r_next          = '0;
      r_next.gain     = GAIN_RESET;
      r_next.offset   = OFFSET_RESET;
      r_next.width    = XW'(SENSOR_W);
      r_next.height   = XW'(SENSOR_H);
      r_next.hbin     = BIN_OFF;
      r_next.vbin     = BIN_OFF;
      r_next.period   = PERIOD_RESET;
      r_next.exposure = EXPOSURE_RESET;
      r_next.debounce = DEBOUNCE_RESET;
      r_next.state    = ST_IDLE;
      r_next.src      = SRC_FREE_RUN;
      r_next.fmt      = FMT_MONO8;
    end
  end

  // single state register
  always_ff @(posedge clk) begin
    r_reg <= r_next;
  end

  // mirror stage adds one line of latency in both flip settings
  rbt_line_mirror #(.PW(10), .XW(XW)) u_mirror (
    .clk   (clk),
    .rst_b (rst_b),
    .pix   (pix)
  );

  assign pix.valid = r_reg.pvalid;
  assign pix.data  = r_reg.pdata;
  assign pix.col   = r_reg.pcol;
  assign pix.last  = r_reg.plast;
  assign pix.flip  = r_reg.flip;
  assign pix.width = eff_w;

  // outputs
  assign reg_rdata        = r_reg.rdata;
  assign analog_gain_code = r_reg.gain;
  assign dc_offset_code   = r_reg.offset;
  assign bin_horiz        = (r_reg.hbin == BIN_TWO);
  assign bin_vert         = (r_reg.vbin == BIN_TWO);
  assign expose           = (r_reg.state == ST_EXPOSE);
  assign line_tick        = r_reg.tick;
  assign out_valid        = pix.out_valid;
  assign out_data         = pix.out_data;
  assign out_last         = pix.out_last;
  assign frame_done       = r_reg.done;
endmodule

/* rbt_roi_control_asserts.sv */
// concurrent checks on the control block ports
`timescale 1ns/100ps
module rbt_roi_control_asserts
  import rbt_pkg::*;
#(
  parameter logic [31:0] MIN_EXP = 32'h4
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // front end and stream
  input wire logic [15:0] analog_gain_code,
  input wire logic [7:0]  dc_offset_code,
  input wire logic        bin_horiz,
  input wire logic        bin_vert,
  input wire logic        expose,
  input wire logic        line_tick,
  input wire logic        out_last,
  input wire logic        out_valid,
  input wire logic        frame_done
);
  logic [31:0] exp_run;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // cycles spent exposing so far; a counter, since repetition cannot reach the minimum
  always_ff @(posedge clk) begin
    if (!rst_b || !expose) begin
      exp_run <= 32'h0;
    end else begin
      exp_run <= exp_run + 32'h1;
    end
  end
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data present without a read");
  a_gain_range: assert property ($signed(analog_gain_code) >= -60 && $signed(analog_gain_code) <= 120)
    else $error("gain code outside range");
  a_offset_write: assert property (reg_wr && reg_addr == REG_OFFSET |=> dc_offset_code == 8'($past(reg_wdata)))
    else $error("offset code not taken from write");
  a_bin_hold: assert property (!(reg_wr && reg_addr == REG_BINNING) |=> $stable(bin_horiz) && $stable(bin_vert))
    else $error("binning changed without a write");
  a_tick_pulse: assert property (line_tick |=> !line_tick [*3])
    else $error("line tick too close");
  a_tick_period: assert property (line_tick |-> ##[4:8] line_tick)
    else $error("line tick missing");
  a_expose_min: assert property ($fell(expose) |-> exp_run >= MIN_EXP)
    else $error("exposure shorter than minimum");
  a_last_valid: assert property (out_last |-> out_valid)
    else $error("line end without pixel");
  a_done_pulse: assert property (frame_done |=> !frame_done)
    else $error("frame done longer than a cycle");
endmodule
bind rbt_roi_control rbt_roi_control_asserts #(.MIN_EXP(MIN_EXP)) u_chk (.clk(clk), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .analog_gain_code(analog_gain_code), .dc_offset_code(dc_offset_code), .bin_horiz(bin_horiz),
  .bin_vert(bin_vert), .expose(expose), .line_tick(line_tick), .out_last(out_last), .out_valid(out_valid),
  .frame_done(frame_done));

/* rbt_sensor_model.sv */
// sensor model: full rows after each exposure, gaps long enough for line playback
`timescale 1ns/100ps
module rbt_sensor_model #(
  parameter int SW = 16,
  parameter int SH = 8
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // control from the block
  input  wire logic       expose,
  input  wire logic       frame_done,
  // pixels, value is {row, column}
  output logic            sensor_valid,
  output logic      [9:0] sensor_data
);
  logic act;
  int   row;
  int   col;
  // data line toggles while idle so a stale pixel never looks valid
  always @(posedge clk) begin
    if (!rst_b) begin
      act <= 1'b0;
      sensor_valid <= 1'b0;
      sensor_data <= 10'h0;
    end else if (frame_done) begin
      act <= 1'b0;
      sensor_valid <= 1'b0;
    end else if (expose) begin
      act <= 1'b1;
      row <= 0;
      col <= 0;
      sensor_valid <= 1'b0;
    end else if (act && row < SH) begin
      sensor_valid <= (col < SW);
      sensor_data <= (col < SW) ? {5'(row), 5'(col)} : ~sensor_data;
      row <= (col == 2 * SW + 3) ? row + 1 : row;
      col <= (col == 2 * SW + 3) ? 0 : col + 1;
    end else begin
      sensor_valid <= 1'b0;
      sensor_data <= ~sensor_data;
    end
  end
endmodule

/* rbt_roi_control_tb.sv */
// self-checking bench for the roi, binning and trigger control block
`timescale 1ns/100ps
module rbt_roi_control_tb;
  import rbt_pkg::*;
  logic clk, rst_b, reg_wr, reg_rd, ext_trigger, sensor_valid;
  logic [7:0] reg_addr, dc_offset_code;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [9:0] sensor_data, out_data;
  logic [15:0] analog_gain_code;
  logic bin_horiz, bin_vert, expose, line_tick, out_valid, out_last, frame_done;
  int fails, num_checks, lines, dones, cyc, tick_at;
  logic [9:0] pix_q[$];
  rbt_roi_control #(.SENSOR_W(16), .SENSOR_H(8), .LINE_CYC(32'h8), .MIN_EXP(32'h4)) uut (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sensor_valid(sensor_valid), .sensor_data(sensor_data), .ext_trigger(ext_trigger),
    .analog_gain_code(analog_gain_code), .dc_offset_code(dc_offset_code), .bin_horiz(bin_horiz),
    .bin_vert(bin_vert), .expose(expose), .line_tick(line_tick), .out_valid(out_valid), .out_data(out_data),
    .out_last(out_last), .frame_done(frame_done));
  rbt_sensor_model u_sensor (.clk(clk), .rst_b(rst_b), .expose(expose),
    .frame_done(frame_done), .sensor_valid(sensor_valid), .sensor_data(sensor_data));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // collect the output stream and line timing
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (out_valid === 1'b1) pix_q.push_back(out_data);
    if (out_last === 1'b1) lines <= lines + 1;
    if (frame_done === 1'b1) dones <= dones + 1;
    if (line_tick === 1'b1) tick_at <= cyc;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic complete_run;
    if (fails == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // reset values, gain clamping and signed offset
  task automatic t_levels;
    rd(REG_GAIN, d); check(d, 32'h0);
    rd(REG_PERIOD, d); check(d, PERIOD_RESET);
    wr(REG_GAIN, 32'hffffff9c); tick(1); check(analog_gain_code, 16'hffc4);
    wr(REG_GAIN, 32'h000000c8); tick(1); check(analog_gain_code, 16'h0078);
    wr(REG_OFFSET, 32'h00000080); tick(1); check(dc_offset_code, 8'h80);
    rd(REG_OFFSET, d); check(d, 32'hffffff80);
    rd(8'h40, d); check(d, 32'h0);
  endtask
  // binning codes and halved maxima per axis
  task automatic t_binning;
    wr(REG_BINNING, 32'ha); tick(1); check({bin_horiz, bin_vert}, 2'b11);
    rd(REG_EFFECTIVE, d); check(d, 32'h00080004);
    wr(REG_BINNING, 32'h9); tick(1); check({bin_horiz, bin_vert}, 2'b01);
    rd(REG_EFFECTIVE, d); check(d, 32'h00100004);
    wr(REG_BINNING, 32'h5); tick(1); check({bin_horiz, bin_vert}, 2'b00);
  endtask
  // window clamps against the offset, then a small legal window (even values)
  task automatic t_window;
    wr(REG_LEFT, 32'h2); wr(REG_TOP, 32'h1);
    wr(REG_WIDTH, 32'd20); wr(REG_HEIGHT, 32'd50);
    rd(REG_WIDTH, d); check(d, 32'd14);
    rd(REG_HEIGHT, d); check(d, 32'd7);
    wr(REG_WIDTH, 32'h4); wr(REG_HEIGHT, 32'h2);
  endtask
  // one frame through the window, triggered by software or the pin
  task automatic run_frame(input logic flip, input logic fmt, input bit ext);
    int n, k, j, c;
    wr(REG_FORMAT, {30'h0, flip, fmt});
    rd(REG_STRIDE, d); check(d, fmt ? 32'h8 : 32'h4);
    pix_q.delete(); lines = 0; dones = 0; n = 0;
    if (ext) begin
      @(posedge clk) ext_trigger <= 1'b1;
      repeat (12) @(posedge clk);
      ext_trigger <= 1'b0;
    end else wr(REG_SOFT_TRIG, 32'h1);
    while ((lines < 2 || dones == 0) && n < 3000) begin tick(1); n++; end
    check(lines, 2);
    check(pix_q.size(), 8);
    for (k = 0; k < 2; k++) for (j = 0; j < 4; j++) begin
      c = flip ? 5 - j : 2 + j;
      d = {22'h0, 5'(1 + k), 5'(c)};
      if (fmt) check(pix_q[k * 4 + j], d);
      else check(pix_q[k * 4 + j], d >> 2);
    end
  endtask
  // trigger sources: refused soft write, glitch filter, then pin and soft frames
  task automatic t_triggers;
    int n, hit;
    wr(REG_EXPOSURE, 32'd10); wr(REG_DEBOUNCE, 32'h3); wr(REG_TRIGGER, 32'h1);
    wr(REG_SOFT_TRIG, 32'h1);
    @(posedge clk) ext_trigger <= 1'b1;
    @(posedge clk) ext_trigger <= 1'b0;
    hit = 0;
    for (n = 0; n < 20; n++) begin tick(1); if (expose === 1'b1) hit = 1; end
    check(hit, 0);
    run_frame(1'b1, 1'b1, 1'b1);
    wr(REG_TRIGGER, 32'h2);
    run_frame(1'b0, 1'b0, 1'b0);
  endtask
  // free run straight out of reset: exposure follows the first line tick, then a full frame is read
  task automatic t_free_run;
    int n;
    n = 0;
    tick(1);
    while (expose !== 1'b1 && n < 20) begin tick(1); n++; end
    check(expose, 1'b1);
    check(cyc - tick_at <= 2, 1'b1);
    while ((lines < 8 || dones == 0) && n < 25000) begin tick(1); n++; end
    check(lines, 8);
    check(pix_q.size(), 128);
  endtask
  // give a hang a bounded span; the reset exposure alone takes about 100 us
  initial begin
    #200000;
    fails++;
    complete_run();
  end
  initial begin
    rst_b = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h0; reg_wdata = 32'h0; ext_trigger = 1'b0;
    fails = 0; num_checks = 0; lines = 0; dones = 0; cyc = 0; tick_at = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    wr(REG_TRIGGER, 32'h2);
    t_free_run();
    t_levels();
    t_binning();
    t_window();
    t_triggers();
    complete_run();
  end
endmodule
